// ==== testbench/pbc_bus_ctrl_properties.sv ====
// pbc_bus_ctrl_properties.sv: pin timing checks for the bus controller
// assumes it is bound onto pbc_bus_ctrl, one clock, async low reset
`timescale 1ns/1ps
module pbc_props (
	input wire I_CORE_CLK,
	input wire I_RESETN,
	input wire I_RESET,
	input wire I_HOLD,
	input wire O_ADDRESS_STROBE_N,
	input wire O_LOCK_N,
	input wire O_BUS_OE,
	input wire O_DATA_OE,
	input wire O_BUS_HOLD_ACK,
	input wire O_PENDING_BUS_REQUEST,
	input wire O_EIGHT_BIT_BUS_MODE
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESETN);
	property p_float; O_BUS_HOLD_ACK |-> !O_BUS_OE && !O_DATA_OE; endproperty
	a_float: assert property (p_float) else $error("pins driven in hold");
	property p_idle; O_BUS_HOLD_ACK |-> O_ADDRESS_STROBE_N; endproperty
	a_idle: assert property (p_idle) else $error("strobe in hold");
	property p_lock; O_BUS_HOLD_ACK |-> O_LOCK_N; endproperty
	a_lock: assert property (p_lock) else $error("bus given up locked");
	property p_gap; !O_ADDRESS_STROBE_N |=> O_ADDRESS_STROBE_N; endproperty
	a_gap: assert property (p_gap) else $error("strobes too close");
	// hold passes a synchroniser, so the grant trails it by four edges
	property p_sync; $rose(O_BUS_HOLD_ACK) |-> $past(I_HOLD, 3); endproperty
	a_sync: assert property (p_sync) else $error("ack too early");
	property p_drop; $fell(I_HOLD) |-> ##[1:5] !O_BUS_HOLD_ACK; endproperty
	a_drop: assert property (p_drop) else $error("ack held");
	property p_pending_bus_request; O_PENDING_BUS_REQUEST && O_BUS_HOLD_ACK |=> O_PENDING_BUS_REQUEST; endproperty
	a_pending_bus_request: assert property (p_pending_bus_request) else $error("request dropped");
	property p_rst; I_RESET [*5] |-> O_ADDRESS_STROBE_N; endproperty
	a_rst: assert property (p_rst) else $error("strobe in reset");
	c_hold: cover property ($rose(O_BUS_HOLD_ACK));
	c_pipe: cover property (!O_ADDRESS_STROBE_N ##2 !O_ADDRESS_STROBE_N);
	c_narrow: cover property (O_EIGHT_BIT_BUS_MODE && !O_ADDRESS_STROBE_N);
endmodule // pbc_props
bind pbc_bus_ctrl pbc_props u_props (.I_CORE_CLK, .I_RESETN, .I_RESET, .I_HOLD,
	.O_ADDRESS_STROBE_N, .O_LOCK_N, .O_BUS_OE, .O_DATA_OE, .O_BUS_HOLD_ACK,
	.O_PENDING_BUS_REQUEST, .O_EIGHT_BIT_BUS_MODE);

// ==== testbench/pbc_bus_ctrl_test.sv ====
// pbc_bus_ctrl_test.sv: random and corner traffic through the bus controller
// assumes pbc_mem_model on the pins and the checker bound to the design
`timescale 1ns/1ps
module pbc_bus_ctrl_test;
	logic clk, rst_n, rst, valid, wr, lk, tbl, hold, strap, slow, narrow;
	logic [31:0] addr;
	wire rdy, rv, rdy_n, na_n, oe, bus_oe, ack, pending_bus_request, mode, lock_n, stb_n, w;
	wire [31:0] a;
	wire [63:0] rd, din, dout;
	wire [1:0] cco;
	int failures, checks_done, n;
	int seed = 32'h2096;
	logic [31:0] rq[$];
	pbc_bus_ctrl dut (.I_CORE_CLK(clk), .I_RESETN(rst_n), .I_RESET(rst), .I_REQ_VALID(valid),
		.O_REQ_READY(rdy), .I_REQ_WRITE(wr), .I_REQ_LOCK(lk | tbl), .I_REQ_ADDR(addr),
		.I_REQ_WDATA({2{addr}}), .I_BUS_LOCK_BIT(lk), .I_TABLE_UPDATE(tbl),
		.O_RDATA_VALID(rv), .O_RDATA(rd), .I_READY_N(rdy_n), .I_NEXT_ADDRESS_REQ_N(na_n),
		.I_HOLD(hold), .I_INTERRUPT_OR_NARROW_STRAP(strap), .I_CACHE_CONTROL_INPUTS(addr[1:0]),
		.I_DATA(din), .O_DATA(dout), .O_DATA_OE(oe), .O_ADDR(a), .O_WRITE(w),
		.O_ADDRESS_STROBE_N(stb_n), .O_LOCK_N(lock_n), .O_BUS_OE(bus_oe), .O_BUS_HOLD_ACK(ack),
		.O_PENDING_BUS_REQUEST(pending_bus_request), .O_EIGHT_BIT_BUS_MODE(mode), .O_CACHE_CTRL(cco));
	pbc_mem_model mem (.clk(clk), .rst_n(rst_n), .strobe_n(stb_n), .addr(a), .slow(slow),
		.ready_n(rdy_n), .na_n(na_n), .data(din));
	function automatic logic [63:0] exp_rd(logic [31:0] x);
		return narrow ? {56'h0, x[7:0]} : {~x, x};
	endfunction
	task chk(string nm, logic [63:0] e, logic [63:0] s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s exp %h got %h", nm, e, s);
		end
	endtask
	task conclude;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// called at a falling edge; returns at the falling edge after acceptance
	task send(bit wt);
		valid = 1;
		wr = wt;
		addr = $random(seed);
		while (rdy !== 1'b1) @(negedge clk);
		if (!wt) rq.push_back(addr & 32'h7FFFFFFF);
		@(negedge clk);
	endtask
	task drain;
		n = 0;
		while (rq.size() && n < 400) begin
			@(negedge clk);
			n++;
		end
		repeat (30) @(negedge clk);
	endtask
	// strap flips with the reset release, so only the last reset clock counts
	task dev_reset(bit s);
		rst = 1;
		strap = s;
		hold = 1;
		repeat (8) @(negedge clk);
		chk("ack_reset", 1, ack);
		hold = 0;
		repeat (8) @(negedge clk);
		rst = 0;
		strap = !s;
		narrow = s;
		repeat (8) @(negedge clk);
		chk("narrow", s, mode);
		$display("reset test done");
	endtask
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude();
	end
	// reads return in issue order
	always @(negedge clk) if (rv === 1'b1) chk("rdata", exp_rd(rq.pop_front()), rd);
	initial begin
		{rst_n, rst, valid, wr, lk, tbl, hold, strap, slow, narrow} = 0;
		addr = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		dev_reset(1);
		repeat (8) send(0);
		valid = 0;
		drain();
		dev_reset(0);
		for (int i = 0; i < 80; i++) begin
			slow = i[5];
			send($random(seed));
		end
		valid = 0;
		drain();
		$display("random test done");
		// each lock source, held through the idle, released by an unlocked cycle
		for (int s = 0; s < 2; s++) begin
			{tbl, lk} = s ? 2'b10 : 2'b01;
			repeat (3) send(s);
			valid = 0;
			drain();
			chk("lock_idle", 0, lock_n);
			{tbl, lk} = 0;
			send(0);
			valid = 0;
			drain();
			chk("lock_off", 1, lock_n);
		end
		$display("lock test done");
		// hold stalls the bus while the request buffer fills
		hold = 1;
		drain();
		chk("ack", 1, ack);
		chk("bus_oe", 0, bus_oe);
		valid = 1;
		wr = 0;
		n = 0;
		while (rdy === 1'b1 && n < 40) begin
			rq.push_back(addr & 32'h7FFFFFFF);
			@(negedge clk);
			n++;
		end
		valid = 0;
		chk("fill", 16, n);
		repeat (6) @(negedge clk);
		chk("pending_bus_request", 1, pending_bus_request);
		hold = 0;
		drain();
		chk("empty", 0, rq.size());
		$display("hold test done");
		conclude();
	end
endmodule // pbc_bus_ctrl_test

// ==== testbench/pbc_mem_model.sv ====
// pbc_mem_model.sv: memory side, answers each strobe with ready in issue order
// assumes strobe and address change just after the rising edge
`timescale 1ns/1ps
module pbc_mem_model (
	input wire clk,
	input wire rst_n,
	input wire strobe_n,
	input wire [31:0] addr,
	input wire slow,
	output logic ready_n,
	output logic na_n,
	output logic [63:0] data
);
	int due_q[$];
	logic [31:0] a_q[$];
	int t;
	int seed = 32'h51;
	// ready never on two edges in a row; data inverts when not answering
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_n <= 1'b1;
			na_n <= 1'b1;
			data <= 64'h0;
			t = 0;
			due_q.delete();
			a_q.delete();
		end else begin
			t++;
			if (ready_n && due_q.size() && due_q[0] <= t) begin
				ready_n <= 1'b0;
				data <= {~a_q[0], a_q[0]};
				void'(due_q.pop_front());
				void'(a_q.pop_front());
			end else begin
				ready_n <= 1'b1;
				data <= ~data;
			end
			// fast cycles go without next-address, slow ones pipeline
			na_n <= !(slow && due_q.size() && $random(seed) % 2);
			if (!strobe_n) begin
				due_q.push_back(t + 1 + (slow ? 3 : 0));
				a_q.push_back(addr);
			end
		end
	end
endmodule // pbc_mem_model

// ==== verilog/pbc_bus_ctrl.v ====
// pbc_bus_ctrl.v: external bus controller with three-level address pipelining
// assumes pin inputs are asynchronous to I_CORE_CLK and internal requests are not
`timescale 1ns/1ps
`include "pbc_defs.vh"
module pbc_bus_ctrl (
	input wire I_CORE_CLK,
	input wire I_RESETN,
	input wire I_RESET,
	input wire I_REQ_VALID,
	output wire O_REQ_READY,
	input wire I_REQ_WRITE,
	input wire I_REQ_LOCK,
	input wire [`PBC_AW-1:0] I_REQ_ADDR,
	input wire [`PBC_DW-1:0] I_REQ_WDATA,
	input wire I_BUS_LOCK_BIT,
	input wire I_TABLE_UPDATE,
	output reg O_RDATA_VALID,
	output reg [`PBC_DW-1:0] O_RDATA,
	input wire I_READY_N,
	input wire I_NEXT_ADDRESS_REQ_N,
	input wire I_HOLD,
	input wire I_INTERRUPT_OR_NARROW_STRAP,
	input wire [1:0] I_CACHE_CONTROL_INPUTS,
	input wire [`PBC_DW-1:0] I_DATA,
	output reg [`PBC_DW-1:0] O_DATA,
	output reg O_DATA_OE,
	output reg [`PBC_AW-1:0] O_ADDR,
	output reg O_WRITE,
	output reg O_ADDRESS_STROBE_N,
	output reg O_LOCK_N,
	output reg O_BUS_OE,
	output reg O_BUS_HOLD_ACK,
	output reg O_PENDING_BUS_REQUEST,
	output reg O_EIGHT_BIT_BUS_MODE,
	output reg [1:0] O_CACHE_CTRL
);
	// bus state encodings: idle, hold, and one strobe and one wait state shared by all levels
	localparam ST_IDLE = 3'h0;
	localparam ST_HOLD = 3'h1;
	localparam ST_ADS = 3'h2;
	localparam ST_WAIT = 3'h3;

	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [1:0] out_q;
	reg [1:0] out_d;
	reg na_seen_q;
	reg na_seen_d;
	reg ready_blank_q;
	reg [1:0] rdy_s1_q, rdy_s2_q;
	reg [1:0] hold_s1_q, hold_s2_q;
	reg hold_int_q;
	reg strap_s1_q, strap_s2_q;
	reg rst_s1_q, rst_s2_q;
	reg [`PBC_DW-1:0] din_s1_q, din_s2_q;
	reg lock_q;
	reg last_rd_q;
	reg [`PBC_TAG_W-1:0] kind_q;
	reg [1:0] wr_pend_q;
	reg req_locked_q;

	wire fifo_valid;
	wire [`PBC_REQ_W-1:0] fifo_data;
	wire issue;
	wire ready_act;
	wire na_act;
	wire hold_act;
	wire in_reset;
	wire req_wr;
	wire req_lk;
	wire oldest_wr;

	pbc_fifo #(
		.WIDTH(`PBC_REQ_W),
		.DEPTH(`PBC_FIFO_DEPTH),
		.AW(`PBC_FIFO_AW)
	) u_fifo (
		.i_clk(I_CORE_CLK),
		.i_rst_n(I_RESETN),
		.i_wr_valid(I_REQ_VALID),
		.o_wr_ready(O_REQ_READY),
		.i_wr_data({I_REQ_LOCK, I_REQ_WRITE, I_REQ_ADDR[`PBC_AW-2:0], I_REQ_WDATA}),
		.o_rd_valid(fifo_valid),
		.i_rd_ready(issue),
		.o_rd_data(fifo_data)
	);

	assign req_lk = fifo_data[`PBC_REQ_W-1];
	assign req_wr = fifo_data[`PBC_REQ_W-2];
	assign oldest_wr = kind_q[0];
	assign in_reset = rst_s2_q;
	// inputs other than hold, strap and cache bits are masked in reset
	assign ready_act = ~rdy_s2_q[0] & ~in_reset & ~ready_blank_q & (out_q != 2'h0);
	assign na_act = ~rdy_s2_q[1] & ~in_reset & (st_q == ST_WAIT);
	assign hold_act = hold_int_q;

	// start a cycle: idle start or pipelined start with all five conditions
	assign issue = fifo_valid & ~in_reset & ~O_BUS_HOLD_ACK & (st_q != ST_ADS)
		& ((out_q == 2'h0 & ~(hold_act & ~lock_q))
		| (out_q != 2'h0 & ~ready_act & (na_seen_q | na_act)
		& (~hold_act | lock_q) & (out_q < `PBC_MAX_OUT)
		& ~(req_wr & ~last_rd_q)));

	// two-flop synchronisers for all pin inputs except the cache control inputs
	always @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rdy_s1_q <= 2'h3;
			rdy_s2_q <= 2'h3;
			hold_s1_q <= 2'h0;
			hold_s2_q <= 2'h0;
			strap_s1_q <= 1'b0;
			strap_s2_q <= 1'b0;
			rst_s1_q <= 1'b1;
			rst_s2_q <= 1'b1;
			din_s1_q <= {`PBC_DW{1'b0}};
			din_s2_q <= {`PBC_DW{1'b0}};
			hold_int_q <= 1'b0;
		end else begin
			rdy_s1_q <= {I_NEXT_ADDRESS_REQ_N, I_READY_N};
			rdy_s2_q <= rdy_s1_q;
			hold_s1_q <= {hold_s1_q[1], I_HOLD};
			hold_s2_q <= hold_s1_q;
			strap_s1_q <= I_INTERRUPT_OR_NARROW_STRAP;
			strap_s2_q <= strap_s1_q;
			rst_s1_q <= I_RESET;
			rst_s2_q <= rst_s1_q;
			din_s1_q <= I_DATA;
			din_s2_q <= din_s1_q;
			hold_int_q <= hold_s2_q[0]; // one more clock of internal delay
		end
	end

	// bus state machine next state; hold entered only from idle
	always @* begin
		st_d = st_q;
		out_d = out_q;
		na_seen_d = na_seen_q;
		if (ready_act) begin
			na_seen_d = 1'b0;
		end else if (na_act) begin
			na_seen_d = 1'b1; // remembered even with no request pending
		end
		case (st_q)
			ST_IDLE: begin
				if (hold_act & ~lock_q & ~issue) begin
					st_d = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (~hold_s2_q[0]) begin
					st_d = ST_IDLE; // release the clock after hold drops
				end
			end
			ST_ADS: begin
				st_d = ST_WAIT;
			end
			default: begin
				if (out_q == 2'h1 & ready_act & ~issue) begin
					st_d = ST_IDLE; // nonpipelined when next-address never came
				end
			end
		endcase
		if (issue) begin
			st_d = ST_ADS; // alternates strobe and wait up to level three
			na_seen_d = 1'b0;
		end
		// level counter: +1 per strobe, -1 per ready
		out_d = out_q + {1'b0, issue} - {1'b0, ready_act};
	end

	// state, ready blanking and per-cycle bookkeeping
	always @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st_q <= ST_IDLE;
			out_q <= 2'h0;
			na_seen_q <= 1'b0;
			ready_blank_q <= 1'b0;
			kind_q <= {`PBC_TAG_W{1'b0}};
			last_rd_q <= 1'b0;
			wr_pend_q <= 2'h0;
			req_locked_q <= 1'b0;
		end else begin
			st_q <= st_d;
			out_q <= out_d;
			na_seen_q <= na_seen_d;
			ready_blank_q <= ready_act; // ready not resampled the clock after
			// shift register of read/write kind per outstanding cycle, oldest in bit 0
			if (issue & ready_act) begin
				kind_q <= (kind_q >> 1) | ({{(`PBC_TAG_W-1){1'b0}}, req_wr} << (out_q - 2'h1));
			end else if (issue) begin
				kind_q <= kind_q | ({{(`PBC_TAG_W-1){1'b0}}, req_wr} << out_q);
			end else if (ready_act) begin
				kind_q <= kind_q >> 1;
			end
			if (issue) begin
				last_rd_q <= ~req_wr;
				req_locked_q <= req_lk;
			end
			// write data waits one clock after a read returns
			if (issue & req_wr & (out_q == 2'h0 | ~last_rd_q)) begin
				wr_pend_q <= 2'h2;
			end else if (issue & req_wr) begin
				wr_pend_q <= 2'h1;
			end else if (wr_pend_q == 2'h1 & ready_act & ~oldest_wr) begin
				wr_pend_q <= 2'h2; // read data is back: keep driving until the write ends
			end else if (ready_act & oldest_wr) begin
				wr_pend_q <= 2'h0;
			end
		end
	end

	// pin outputs, floated under hold acknowledge
	always @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_ADDRESS_STROBE_N <= 1'b1;
			O_ADDR <= {`PBC_AW{1'b0}};
			O_WRITE <= 1'b0;
			O_DATA <= {`PBC_DW{1'b0}};
			O_DATA_OE <= 1'b0;
			O_LOCK_N <= 1'b1;
			lock_q <= 1'b0;
			O_BUS_OE <= 1'b1;
			O_BUS_HOLD_ACK <= 1'b0;
			O_PENDING_BUS_REQUEST <= 1'b0;
			O_EIGHT_BIT_BUS_MODE <= 1'b0;
			O_CACHE_CTRL <= 2'h0;
			O_RDATA_VALID <= 1'b0;
			O_RDATA <= {`PBC_DW{1'b0}};
		end else begin
			O_ADDRESS_STROBE_N <= ~issue;
			if (issue) begin
				O_ADDR <= {1'b0, fifo_data[`PBC_REQ_W-3:`PBC_DW]};
				O_WRITE <= req_wr;
				O_DATA <= fifo_data[`PBC_DW-1:0];
			end
			// drive data only from the second clock of a write
			O_DATA_OE <= (wr_pend_q == 2'h2) | (wr_pend_q == 2'h1 & ready_act & ~oldest_wr);
			// lock held across idles while the last request carried I_REQ_LOCK, until an unlocked cycle starts
			if (issue) begin
				lock_q <= req_lk | I_BUS_LOCK_BIT | I_TABLE_UPDATE;
			end else if (out_q == 2'h0 & ~req_locked_q) begin
				lock_q <= 1'b0;
			end
			O_LOCK_N <= ~(issue ? (req_lk | I_BUS_LOCK_BIT | I_TABLE_UPDATE) : lock_q);
			O_BUS_HOLD_ACK <= (st_d == ST_HOLD);
			O_BUS_OE <= ~(st_d == ST_HOLD);
			// bus request shown while hold granted, held to the strobe clock
			O_PENDING_BUS_REQUEST <= fifo_valid & (O_BUS_HOLD_ACK | (st_q == ST_HOLD)
				| ~O_ADDRESS_STROBE_N | issue);
			// strap caught while reset is still asserted; last value wins
			if (in_reset) begin
				O_EIGHT_BIT_BUS_MODE <= strap_s2_q;
				O_CACHE_CTRL <= I_CACHE_CONTROL_INPUTS;
			end
			O_RDATA_VALID <= ready_act & ~oldest_wr;
			if (ready_act & ~oldest_wr) begin
				// narrow mode keeps only byte zero
				O_RDATA <= O_EIGHT_BIT_BUS_MODE ?
					{{(`PBC_DW-`PBC_NARROW_W){1'b0}}, din_s2_q[`PBC_NARROW_W-1:0]} : din_s2_q;
			end
		end
	end
	// two-clock cycles pass through issue->ready without next-address
endmodule // pbc_bus_ctrl

// ==== verilog/pbc_defs.vh ====
// pbc_defs.vh: constants for the pipelined bus controller
// assumes inclusion by bare name from the design files
`ifndef PBC_DEFS_VH
`define PBC_DEFS_VH
`define PBC_DW 64
`define PBC_AW 32
`define PBC_NARROW_W 8
`define PBC_REQ_W 97
`define PBC_FIFO_DEPTH 16
`define PBC_FIFO_AW 4
`define PBC_MAX_OUT 2'h3
`define PBC_OUT_W 2
`define PBC_TAG_W 3
`endif

// ==== verilog/pbc_fifo.v ====
// pbc_fifo.v: request FIFO with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`include "pbc_defs.vh"
module pbc_fifo #(
	parameter WIDTH = `PBC_REQ_W,
	parameter DEPTH = `PBC_FIFO_DEPTH,
	parameter AW = `PBC_FIFO_AW
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_wr_valid,
	output wire o_wr_ready,
	input wire [WIDTH-1:0] i_wr_data,
	output wire o_rd_valid,
	input wire i_rd_ready,
	output reg [WIDTH-1:0] o_rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	reg out_valid_q;
	wire do_wr;
	wire mem_rd;
	wire pop;

	// head word sits in a register; memory feeds it when emptied or popped
	assign pop = out_valid_q & i_rd_ready;
	assign mem_rd = (cnt_q != {(AW+1){1'b0}}) & (~out_valid_q | pop);
	// the head register counts as one of the DEPTH words, so capacity is DEPTH in all
	assign o_wr_ready = ((cnt_q + {{AW{1'b0}}, out_valid_q}) < DEPTH);
	assign do_wr = i_wr_valid & o_wr_ready;
	assign o_rd_valid = out_valid_q;

	// storage array, no reset needed on data
	always @(posedge i_clk) begin
		if (do_wr) begin
			mem[wp_q] <= i_wr_data;
		end
		if (mem_rd) begin
			o_rd_data <= mem[rp_q];
		end
	end

	// pointers and occupancy
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			out_valid_q <= 1'b0;
		end else begin
			if (do_wr) begin
				wp_q <= wp_q + 1'b1;
			end
			if (mem_rd) begin
				rp_q <= rp_q + 1'b1;
			end
			if (do_wr & ~mem_rd) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (~do_wr & mem_rd) begin
				cnt_q <= cnt_q - 1'b1;
			end
			if (mem_rd) begin
				out_valid_q <= 1'b1;
			end else if (pop) begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule // pbc_fifo
